/* File: inc/pcl_pkg.sv */
package pcll_pkg;
    // Widths of the counter and its sources
    localparam int PC_W = 15;
    localparam int LOW_W = 8;
    localparam int HIGH_W = 7;
    localparam int CALL_W = 11;
    localparam int BRANCH_W = 9;
    // Return stack size
    localparam int STACK_DEPTH = 16;
    localparam int SP_W = 4;
    // Reset values
    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [6:0] LATCH_RESET = 7'h00;
    localparam logic [6:0] SHADOW_RESET = 7'h00;
    // Step of a sequential fetch
    localparam logic [14:0] PC_STEP = 15'h0001;

    // Address source chosen by the decoder
    typedef enum logic [2:0] {
        PCLL_OP_SEQ = 3'b000,
        PCLL_OP_WRLOW = 3'b001,
        PCLL_OP_CALL_LIT = 3'b010,
        PCLL_OP_CALL_ACC = 3'b011,
        PCLL_OP_BR_ACC = 3'b100,
        PCLL_OP_BR_LIT = 3'b101,
        PCLL_OP_HOLD = 3'b110,
        PCLL_OP_RETURN = 3'b111
    } pcll_op_t;
endpackage : pcll_pkg

/* File: core/pcl_program_counter.sv */
// Contract
// - Counter is 15 bits; low byte readable and writable by software.
// - Upper seven bits not directly accessible; software sets them only through high latch.
// - Every reset clears the whole counter to zero.
// - Write to low byte also copies high latch into upper bits.
// - Literal call: operand gives low byte and bits 10:8; latch gives 14:11.
// - Accumulator call: low byte from accumulator, upper bits from latch.
// - Accumulator branch: counter plus one plus unsigned accumulator.
// - Literal branch: counter plus one plus signed operand.
// - Branch offset applies to the already incremented counter.
// - Interrupt pushes return address and shadows latch; return restores both.
module pcll_program_counter #(
    parameter int STACK_DEPTH = pcll_pkg::STACK_DEPTH,
    parameter int SP_W = pcll_pkg::SP_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Decoder controls
    input wire pcll_pkg::pcll_op_t op,
    input wire logic [10:0] callOperand,
    input wire logic [8:0] branchOffset,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] lowWriteData,
    // High latch software write
    input wire logic latchWrite,
    input wire logic [6:0] latchWriteData,
    // Interrupt entry
    input wire logic irqEnter,
    // Outputs
    output logic [14:0] pc,
    output logic [7:0] pcLowByte,
    output logic [6:0] pcHighLatch
);
    // Refuse a stack size that the pointer cannot index exactly
    if (STACK_DEPTH != (2 ** SP_W)) begin : g_depth_check
        $error("stack depth must equal two to the power of the pointer width");
    end
    if (SP_W < 1) begin : g_width_check
        $error("stack pointer needs at least one bit");
    end

    // Whole state in one struct
    typedef struct packed {
        logic [14:0] pc;
        logic [6:0] latch;
        logic [6:0] shadow;
        logic [SP_W-1:0] sp;
        logic [STACK_DEPTH-1:0][14:0] stack;
    } pcll_state_t;

    pcll_state_t st;
    pcll_state_t next_st;

    // Derived values used by several address sources
    logic [14:0] pcInc;
    logic [14:0] accOffset;
    logic [14:0] litOffset;
    logic [SP_W-1:0] spUp;
    logic [SP_W-1:0] spDown;

    // Incremented counter feeds sequential and branch paths
    assign pcInc = st.pc + pcll_pkg::PC_STEP;

    // Accumulator offset is unsigned, literal offset sign-extended
    assign accOffset = {7'h00, accumulator};
    assign litOffset = {{6{branchOffset[8]}}, branchOffset};

    // Stack pointer neighbours; overflow wraps silently
    assign spUp = st.sp + SP_W'(1);
    assign spDown = st.sp - SP_W'(1);

    // Next-state selection
    always_comb begin
        next_st = st;
        // Software load of the high latch, never of the counter itself
        if (latchWrite) begin
            next_st.latch = latchWriteData;
        end
        // Interrupt entry overrides the decoder
        if (irqEnter) begin
            next_st.stack[st.sp] = st.pc;
            next_st.sp = spUp;
            next_st.shadow = st.latch;
        end else begin
            case (op)
                pcll_pkg::PCLL_OP_SEQ: begin
                    next_st.pc = pcInc;
                end
                pcll_pkg::PCLL_OP_WRLOW: begin
                    // Old latch value is used when written in the same cycle
                    next_st.pc = {st.latch, lowWriteData};
                end
                pcll_pkg::PCLL_OP_CALL_LIT: begin
                    next_st.pc = {st.latch[6:3], callOperand};
                    next_st.stack[st.sp] = pcInc;
                    next_st.sp = spUp;
                end
                pcll_pkg::PCLL_OP_CALL_ACC: begin
                    next_st.pc = {st.latch, accumulator};
                    next_st.stack[st.sp] = pcInc;
                    next_st.sp = spUp;
                end
                pcll_pkg::PCLL_OP_BR_ACC: begin
                    next_st.pc = pcInc + accOffset;
                end
                pcll_pkg::PCLL_OP_BR_LIT: begin
                    next_st.pc = pcInc + litOffset;
                end
                pcll_pkg::PCLL_OP_RETURN: begin
                    // Pop return address and restore the latch copy
                    next_st.sp = spDown;
                    next_st.pc = st.stack[spDown];
                    next_st.latch = st.shadow;
                end
                default: begin
                    next_st.pc = st.pc;
                end
            endcase
        end
    end

    // State register, cleared on reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st.pc <= pcll_pkg::PC_RESET;
            st.latch <= pcll_pkg::LATCH_RESET;
            st.shadow <= pcll_pkg::SHADOW_RESET;
            st.sp <= '0;
            st.stack <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flip-flops
    assign pc = st.pc;
    assign pcLowByte = st.pc[7:0];
    assign pcHighLatch = st.latch;

    // Decoder requests that reach the counter
    sequence s_br_acc_issue;
        op == pcll_pkg::PCLL_OP_BR_ACC && !irqEnter;
    endsequence

    sequence s_br_lit_issue;
        op == pcll_pkg::PCLL_OP_BR_LIT && !irqEnter;
    endsequence

    sequence s_call_issue;
        (op == pcll_pkg::PCLL_OP_CALL_LIT || op == pcll_pkg::PCLL_OP_CALL_ACC) && !irqEnter;
    endsequence

    sequence s_return_issue;
        op == pcll_pkg::PCLL_OP_RETURN && !irqEnter;
    endsequence

    // Reset clears counter and latch
    a_reset_clear: assert property (@(posedge clk) !rst_n |=> pc == pcll_pkg::PC_RESET
        && pcHighLatch == pcll_pkg::LATCH_RESET)
        else $error("pc not cleared by reset");

    // Sequential fetch carries into the upper bits
    a_seq_inc: assert property (@(posedge clk) disable iff (!rst_n)
        op == pcll_pkg::PCLL_OP_SEQ && !irqEnter |=> st.pc == $past(st.pc) + 15'h0001)
        else $error("sequential increment wrong");

    // Low byte write loads all fifteen bits at once
    a_low_write: assert property (@(posedge clk) disable iff (!rst_n)
        op == pcll_pkg::PCLL_OP_WRLOW && !irqEnter
        |=> st.pc == {$past(st.latch), $past(lowWriteData)})
        else $error("low write did not load latch");

    // Literal call mixes operand and latch top bits
    a_call_lit: assert property (@(posedge clk) disable iff (!rst_n)
        op == pcll_pkg::PCLL_OP_CALL_LIT && !irqEnter
        |=> st.pc == {$past(st.latch[6:3]), $past(callOperand)})
        else $error("literal call address wrong");

    // Accumulator call takes the whole latch
    a_call_acc: assert property (@(posedge clk) disable iff (!rst_n)
        op == pcll_pkg::PCLL_OP_CALL_ACC && !irqEnter
        |=> st.pc == {$past(st.latch), $past(accumulator)})
        else $error("accumulator call address wrong");

    // Calls push the incremented counter
    a_call_push: assert property (@(posedge clk) disable iff (!rst_n)
        s_call_issue |=> st.stack[spDown] == $past(st.pc) + 15'h0001
            && st.sp == $past(spUp))
        else $error("call return address not pushed");

    // Accumulator branch from the incremented counter
    a_brw_target: assert property (@(posedge clk) disable iff (!rst_n)
        s_br_acc_issue |=> st.pc == $past(st.pc) + 15'h0001
            + {7'h00, $past(accumulator)})
        else $error("accumulator branch target wrong");

    // Literal branch with a signed offset
    a_bra_target: assert property (@(posedge clk) disable iff (!rst_n)
        s_br_lit_issue |=> st.pc == $past(st.pc) + 15'h0001
            + {{6{$past(branchOffset[8])}}, $past(branchOffset)})
        else $error("literal branch target wrong");

    // Interrupt entry saves latch and counter
    a_irq_shadow: assert property (@(posedge clk) disable iff (!rst_n)
        irqEnter |=> st.shadow == $past(st.latch) && st.pc == $past(st.pc)
            && st.stack[spDown] == $past(st.pc))
        else $error("interrupt entry save wrong");

    // Return restores the pushed address and the latch copy
    a_return_restore: assert property (@(posedge clk) disable iff (!rst_n)
        s_return_issue |=> st.pc == $past(st.stack[spDown])
            && st.latch == $past(st.shadow))
        else $error("return did not restore state");

    // Hold keeps the whole counter unchanged
    a_hold_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        op == pcll_pkg::PCLL_OP_HOLD && !irqEnter |=> pc == $past(pc))
        else $error("counter moved while held");

    // Latch takes software data when nothing restores it
    a_latch_load: assert property (@(posedge clk) disable iff (!rst_n)
        latchWrite && !(op == pcll_pkg::PCLL_OP_RETURN && !irqEnter)
        |=> pcHighLatch == $past(latchWriteData))
        else $error("high latch not loaded");
endmodule : pcll_program_counter

/* File: sim/pcl_decoder_model.sv */
module pcll_decoder_model (
    // Clock
    input wire logic clk,
    // Decoder outputs
    output pcll_pkg::pcll_op_t op,
    output logic [10:0] callOperand,
    output logic [8:0] branchOffset,
    output logic [7:0] accumulator,
    output logic [7:0] lowWriteData,
    output logic latchWrite,
    output logic [6:0] latchWriteData,
    output logic irqEnter
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet decoder at time zero
    initial begin
        op = pcll_pkg::PCLL_OP_HOLD;
        {callOperand, branchOffset, accumulator, lowWriteData} = '0;
        {latchWrite, latchWriteData, irqEnter} = '0;
    end
    // One request for one cycle, then operands scrambled
    task automatic issue(input pcll_pkg::pcll_op_t o, input logic [10:0] v,
            input logic [7:0] lt, input logic irq);
        @(negedge clk);
        op = o;
        {callOperand, branchOffset, accumulator, lowWriteData} = {v, v[8:0], v[7:0], v[7:0]};
        {latchWrite, latchWriteData, irqEnter} = {lt, irq};
        @(negedge clk);
        op = pcll_pkg::PCLL_OP_HOLD;
        {callOperand, branchOffset, accumulator, lowWriteData} = ~{v, v[8:0], v[7:0], v[7:0]};
        {latchWrite, irqEnter} = 2'b00;
        latchWriteData = ~lt[6:0];
    endtask : issue
endmodule : pcll_decoder_model

/* File: sim/program_counter_load_logic_test.sv */
module program_counter_load_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    pcll_pkg::pcll_op_t op;
    logic [10:0] callOperand;
    logic [8:0] branchOffset;
    logic [7:0] accumulator, lowWriteData, pcLowByte;
    logic latchWrite, irqEnter;
    logic [6:0] latchWriteData, pcHighLatch;
    logic [14:0] pc;
    int mismatches = 0;
    int check_count = 0;
    // Clock of 4 ns period
    always #2 clk = ~clk;
    // Decoder model and counter
    pcll_decoder_model dec (.clk(clk), .op(op), .callOperand(callOperand),
        .branchOffset(branchOffset), .accumulator(accumulator), .lowWriteData(lowWriteData),
        .latchWrite(latchWrite), .latchWriteData(latchWriteData), .irqEnter(irqEnter));
    pcll_program_counter uut (.clk(clk), .rst_n(rst_n), .op(op), .callOperand(callOperand),
        .branchOffset(branchOffset), .accumulator(accumulator), .lowWriteData(lowWriteData),
        .latchWrite(latchWrite), .latchWriteData(latchWriteData), .irqEnter(irqEnter),
        .pc(pc), .pcLowByte(pcLowByte), .pcHighLatch(pcHighLatch));
    task automatic chk(input logic [14:0] got, input logic [14:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    task automatic t_low_write();
        dec.issue(pcll_pkg::PCLL_OP_HOLD, 11'h000, 8'h83, 1'b0);
        chk(pc, 15'h0000);
        dec.issue(pcll_pkg::PCLL_OP_WRLOW, 11'h0FF, 8'h00, 1'b0);
        chk(pc, 15'h03FF);
        chk({7'h00, pcLowByte}, 15'h00FF);
        dec.issue(pcll_pkg::PCLL_OP_SEQ, 11'h000, 8'h00, 1'b0);
        chk(pc, 15'h0400);
        $display("low write test done");
    endtask : t_low_write
    task automatic t_calls_branches();
        dec.issue(pcll_pkg::PCLL_OP_CALL_LIT, 11'h123, 8'hFF, 1'b0);
        chk(pc, 15'h0123);
        dec.issue(pcll_pkg::PCLL_OP_CALL_LIT, 11'h123, 8'h00, 1'b0);
        chk(pc, 15'h7923);
        dec.issue(pcll_pkg::PCLL_OP_CALL_ACC, 11'h05A, 8'h00, 1'b0);
        chk(pc, 15'h7F5A);
        dec.issue(pcll_pkg::PCLL_OP_BR_ACC, 11'h0FF, 8'h00, 1'b0);
        chk(pc, 15'h005A);
        dec.issue(pcll_pkg::PCLL_OP_BR_LIT, 11'h1FE, 8'h00, 1'b0);
        chk(pc, 15'h0059);
        $display("call and branch test done");
    endtask : t_calls_branches
    task automatic t_irq_reset();
        dec.issue(pcll_pkg::PCLL_OP_SEQ, 11'h000, 8'h00, 1'b1);
        chk(pc, 15'h0059);
        dec.issue(pcll_pkg::PCLL_OP_WRLOW, 11'h010, 8'h85, 1'b0);
        chk(pc, 15'h7F10);
        dec.issue(pcll_pkg::PCLL_OP_RETURN, 11'h000, 8'h00, 1'b0);
        chk(pc, 15'h0059);
        chk({8'h00, pcHighLatch}, 15'h007F);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        chk(pc, 15'h0000);
        chk({8'h00, pcHighLatch}, 15'h0000);
        $display("interrupt and reset test done");
    endtask : t_irq_reset
    // Main sequence after a five cycle reset
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        chk(pc, 15'h0000);
        t_low_write();
        t_calls_branches();
        t_irq_reset();
        finish_test();
    end
    // Watchdog well beyond the expected twenty-eight cycles
    initial begin
        #2000;
        mismatches++;
        finish_test();
    end
endmodule : program_counter_load_logic_test
